// ---- bbc_core.sv ----
`timescale 1ns/1ps
// single-instruction executor: fed one decoded instruction, reads operands
// from an internal 256-byte register file, writes results, updates flags
module bbc_core (
  input  wire logic              clk_i,
  input  wire logic              arst_n_i,
  input  wire logic              start_i,
  input  wire bbc_pkg::bbc_instr_t instr_i,
  input  wire logic              true_sel_i,
  input  wire logic [7:0]        wr_addr_i,
  input  wire logic [7:0]        wr_data_i,
  input  wire logic              wr_en_i,
  input  wire logic [7:0]        rd_addr_i,
  output logic                   busy_o,
  output logic                   done_o,
  output logic                   illegal_o,
  output logic [15:0]            pc_o,
  output logic [7:0]             sp_o,
  output logic [7:0]             flags_o,
  output logic [7:0]             rd_data_o
);
  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  logic [7:0]           regs_q [256];
  bbc_pkg::bbc_state_t  st_q, st_d;
  bbc_pkg::bbc_instr_t  ins_q, ins_d;
  logic                 tru_q, tru_d;
  logic [15:0]          pc_q, pc_d;
  logic [7:0]           sp_q, sp_d;
  logic [3:0]           cnt_q, cnt_d;
  logic                 done_q, done_d;
  logic                 ill_q, ill_d;
  logic                 we;
  logic [7:0]           wa, wd;
  logic [7:0]           fl_d;

  function automatic logic [7:0] wreg(input logic [3:0] r);
    wreg = {4'hC, r};  // working registers sit at C0h..CFh
  endfunction

  function automatic logic [3:0] cycles(input logic [7:0] op);
    case (op)
      bbc_pkg::OP_BIT_BR: cycles = bbc_pkg::CYC_BTJ;
      bbc_pkg::OP_BIT_OR, bbc_pkg::OP_BIT_XOR:
        cycles = bbc_pkg::CYC_BIT;
      bbc_pkg::OP_CALL: cycles = bbc_pkg::CYC_CALL;
      bbc_pkg::OP_CMP_RR, bbc_pkg::OP_INV_R, bbc_pkg::OP_INV_I,
      bbc_pkg::OP_CARRY_INV, bbc_pkg::OP_ZERO_R, bbc_pkg::OP_ZERO_I:
        cycles = bbc_pkg::CYC_2B;
      bbc_pkg::OP_RET: cycles = bbc_pkg::CYC_RET;
      default: cycles = bbc_pkg::CYC_3B;
    endcase
  endfunction

  bbc_pkg::bbc_bitfld_t bf;
  logic [7:0] dst_a, src_a, dv, sv, res;
  logic [8:0] diff;
  logic       bitv, other0;
  logic [15:0] next_pc;

  assign bf = ins_q.byte2;

  always_comb begin
    dst_a  = 8'h00;
    src_a  = 8'h00;
    next_pc = pc_q + bbc_pkg::LEN_3;
    case (ins_q.opcode)
      bbc_pkg::OP_BIT_OR, bbc_pkg::OP_BIT_XOR: begin
        // sel=0: dst is working reg (bit 0), src is byte3 bit b
        // sel=1: dst is byte3 bit b, src is working reg bit 0
        dst_a = bf.sel ? ins_q.byte3 : wreg(bf.reg_addr);
        src_a = bf.sel ? wreg(bf.reg_addr) : ins_q.byte3;
      end
      bbc_pkg::OP_BIT_BR: src_a = wreg(bf.reg_addr);
      // call is three bytes long, so the return address skips all three
      bbc_pkg::OP_CALL: next_pc = pc_q + bbc_pkg::LEN_3;
      bbc_pkg::OP_CMP_RR, bbc_pkg::OP_CMP_RI: begin
        dst_a = wreg(ins_q.byte2[7:4]);
        src_a = wreg(ins_q.byte2[3:0]);
        next_pc = pc_q + bbc_pkg::LEN_2;
      end
      bbc_pkg::OP_CMP_GG, bbc_pkg::OP_CMP_GI: begin
        src_a = ins_q.byte2;
        dst_a = ins_q.byte3;
      end
      bbc_pkg::OP_CMP_IM: dst_a = ins_q.byte2;
      bbc_pkg::OP_CARRY_INV, bbc_pkg::OP_RET:
        next_pc = pc_q + bbc_pkg::LEN_1;
      default: begin
        dst_a = ins_q.byte2;
        next_pc = pc_q + bbc_pkg::LEN_2;
      end
    endcase
    // indirect forms: operand address comes from the pointer register
    if (ins_q.opcode == bbc_pkg::OP_CMP_RI ||
        ins_q.opcode == bbc_pkg::OP_CMP_GI) begin
      src_a = regs_q[src_a];
    end
    if (ins_q.opcode == bbc_pkg::OP_ZERO_I ||
        ins_q.opcode == bbc_pkg::OP_INV_I) begin
      dst_a = regs_q[dst_a];  // pointer read only, never written
    end
  end

  assign dv = regs_q[dst_a];
  assign sv = (ins_q.opcode == bbc_pkg::OP_CMP_IM) ? ins_q.byte3
                                                  : regs_q[src_a];
  assign bitv   = bf.sel ? dv[bf.bit_idx] : sv[bf.bit_idx];
  assign other0 = bf.sel ? sv[0] : dv[0];
  assign diff   = {1'b0, dv} - {1'b0, sv};

  // ------------------------------------------------------------------
  // next-state and datapath
  // ------------------------------------------------------------------
  always_comb begin
    st_d   = st_q;
    ins_d  = ins_q;
    tru_d  = tru_q;
    pc_d   = pc_q;
    sp_d   = sp_q;
    cnt_d  = cnt_q;
    done_d = 1'b0;
    ill_d  = 1'b0;
    we     = wr_en_i;
    wa     = wr_addr_i;
    wd     = wr_data_i;
    fl_d   = regs_q[bbc_pkg::FLAGS_ADDR];
    res    = 8'h00;
    case (st_q)
      bbc_pkg::BBC_IDLE: begin
        if (start_i) begin
          ins_d = instr_i;
          tru_d = true_sel_i;
          // start edge, exec edge, done edge and the sampling edge of
          // done take four of the documented cycles
          cnt_d = cycles(instr_i.opcode) - 4'h4;
          st_d  = bbc_pkg::BBC_EXEC;
        end
      end
      bbc_pkg::BBC_EXEC: begin
        st_d = bbc_pkg::BBC_WAIT;
        pc_d = next_pc;
        case (ins_q.opcode)
          bbc_pkg::OP_BIT_OR, bbc_pkg::OP_BIT_XOR: begin
            res = dv;
            res[bf.sel ? bf.bit_idx : 3'h0] =
              (ins_q.opcode == bbc_pkg::OP_BIT_OR) ? (bitv | other0)
                                                : (bitv ^ other0);
            we = 1'b1;
            wa = dst_a;
            wd = res;
            if (ins_q.opcode == bbc_pkg::OP_BIT_XOR) begin
              fl_d[bbc_pkg::FLAG_Z] = (res == 8'h00);
              fl_d[bbc_pkg::FLAG_S] = 1'b0;
            end
          end
          bbc_pkg::OP_BIT_BR: begin
            // offset is signed; base is the address past the branch
            if (bitv == tru_q)
              pc_d = next_pc + {{8{ins_q.byte3[7]}}, ins_q.byte3};
          end
          bbc_pkg::OP_CALL: begin
            sp_d = sp_q - 8'h01;
            we   = 1'b1;
            wa   = sp_q - 8'h01;
            wd   = next_pc[7:0];
            st_d = bbc_pkg::BBC_PUSH_HI;
          end
          bbc_pkg::OP_RET: begin
            pc_d[15:8] = regs_q[sp_q];
            sp_d = sp_q + 8'h01;
            st_d = bbc_pkg::BBC_POP_LO;
          end
          bbc_pkg::OP_CARRY_INV:
            fl_d[bbc_pkg::FLAG_C] = ~fl_d[bbc_pkg::FLAG_C];
          bbc_pkg::OP_ZERO_R, bbc_pkg::OP_ZERO_I: begin
            we = 1'b1;
            wa = dst_a;
            wd = 8'h00;
          end
          bbc_pkg::OP_INV_R, bbc_pkg::OP_INV_I: begin
            res = ~dv;
            we  = 1'b1;
            wa  = dst_a;
            wd  = res;
            fl_d[bbc_pkg::FLAG_Z] = (res == 8'h00);
            fl_d[bbc_pkg::FLAG_S] = res[7];
            fl_d[bbc_pkg::FLAG_V] = 1'b0;
          end
          bbc_pkg::OP_CMP_RR, bbc_pkg::OP_CMP_RI, bbc_pkg::OP_CMP_GG,
          bbc_pkg::OP_CMP_GI, bbc_pkg::OP_CMP_IM: begin
            // flags only, no operand write
            fl_d[bbc_pkg::FLAG_C] = diff[8];
            fl_d[bbc_pkg::FLAG_Z] = (diff[7:0] == 8'h00);
            fl_d[bbc_pkg::FLAG_S] = diff[7];
            fl_d[bbc_pkg::FLAG_V] = (dv[7] ^ sv[7]) &
                                    (dv[7] ^ diff[7]);
          end
          default: begin
            ill_d = 1'b1;
            pc_d  = pc_q;
          end
        endcase
      end
      bbc_pkg::BBC_PUSH_HI: begin
        sp_d = sp_q - 8'h01;
        we   = 1'b1;
        wa   = sp_q - 8'h01;
        wd   = pc_q[15:8];
        pc_d = {ins_q.byte2, ins_q.byte3};
        st_d = bbc_pkg::BBC_WAIT;
        cnt_d = cnt_q - 4'h1;
      end
      bbc_pkg::BBC_POP_LO: begin
        pc_d[7:0] = regs_q[sp_q];
        sp_d = sp_q + 8'h01;
        st_d = bbc_pkg::BBC_WAIT;
        cnt_d = cnt_q - 4'h1;
      end
      bbc_pkg::BBC_WAIT: begin
        // fixed latency per opcode, independent of branch outcome
        if (cnt_q == 4'h0) begin
          done_d = 1'b1;
          st_d   = bbc_pkg::BBC_IDLE;
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
      default: st_d = bbc_pkg::BBC_IDLE;
    endcase
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_q   <= bbc_pkg::BBC_IDLE;
      ins_q  <= '0;
      tru_q  <= 1'b0;
      pc_q   <= bbc_pkg::PC_RST;
      sp_q   <= bbc_pkg::SP_RST;
      cnt_q  <= 4'h0;
      done_q <= 1'b0;
      ill_q  <= 1'b0;
    end else begin
      st_q   <= st_d;
      ins_q  <= ins_d;
      tru_q  <= tru_d;
      pc_q   <= pc_d;
      sp_q   <= sp_d;
      cnt_q  <= cnt_d;
      done_q <= done_d;
      ill_q  <= ill_d;
    end
  end

  // register file; flags live at their own address
  always_ff @(posedge clk_i) begin
    if (we) begin
      regs_q[wa] <= wd;
    end
    if (st_q == bbc_pkg::BBC_EXEC && !(we && wa == bbc_pkg::FLAGS_ADDR)) begin
      regs_q[bbc_pkg::FLAGS_ADDR] <= fl_d;
    end
  end

  assign busy_o    = (st_q != bbc_pkg::BBC_IDLE);
  assign done_o    = done_q;
  assign illegal_o = ill_q;
  assign pc_o      = pc_q;
  assign sp_o      = sp_q;
  assign flags_o   = regs_q[bbc_pkg::FLAGS_ADDR];
  assign rd_data_o = regs_q[rd_addr_i];

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  branch_timing_a: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (st_q == bbc_pkg::BBC_IDLE && start_i &&
     instr_i.opcode == bbc_pkg::OP_BIT_BR) |-> ##9 done_q)
    else $error("bit branch did not finish in ten cycles");
  branch_flags_a: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (st_q == bbc_pkg::BBC_EXEC && ins_q.opcode == bbc_pkg::OP_BIT_BR &&
     !wr_en_i)
    |=> $stable(flags_o))
    else $error("bit branch changed flags");
  call_timing_a: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (st_q == bbc_pkg::BBC_IDLE && start_i &&
     instr_i.opcode == bbc_pkg::OP_CALL) |-> ##13 done_q)
    else $error("call did not finish in fourteen cycles");
  call_stack_a: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (st_q == bbc_pkg::BBC_EXEC && ins_q.opcode == bbc_pkg::OP_CALL)
    |-> ##2 (sp_q == $past(sp_q, 2) - 8'h02))
    else $error("call did not drop stack pointer by two");
  call_target_a: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (st_q == bbc_pkg::BBC_PUSH_HI) |=> (pc_q == {ins_q.byte2, ins_q.byte3}))
    else $error("call did not load destination");
  carry_invert_a: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (st_q == bbc_pkg::BBC_EXEC && ins_q.opcode == bbc_pkg::OP_CARRY_INV &&
     !wr_en_i)
    |=> (flags_o == ($past(flags_o) ^ 8'h80)))
    else $error("carry invert wrong");
  invert_timing_a: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (st_q == bbc_pkg::BBC_IDLE && start_i &&
     instr_i.opcode == bbc_pkg::OP_INV_R) |-> ##3 done_q)
    else $error("complement not four cycles");
  cmp_pc_a: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (st_q == bbc_pkg::BBC_EXEC && ins_q.opcode == bbc_pkg::OP_CMP_RR)
    |=> (pc_q == $past(pc_q) + bbc_pkg::LEN_2))
    else $error("short compare did not advance two bytes");
endmodule // bbc_core

// ---- bbc_pkg.sv ----
// Overview of operation
// - bit OR merges chosen bit with bit 0, writes destination bit only.
// - branch on false adds offset when tested bit is zero; 3 bytes, 10 cycles.
// - branch on true adds offset when bit is one; no flag changes.
// - second byte holds 4-bit register, 3-bit bit index, 1-bit form selector.
// - bit XOR writes only destination bit; 3 bytes, 6 cycles.
// - bit XOR sets Z on zero, clears S, keeps C, D, H.
// - call pushes low then high return byte, loads PC; 3 bytes, 14 cycles.
// - pushed address follows the call; return pops it back into PC.
// - carry invert toggles C only.
// - clear writes zero and leaves flags alone.
// - clear supports direct and indirect forms; pointer stays unchanged.
// - complement inverts every bit; register form 2 bytes, 4 cycles.
// - complement sets Z, S from bit 7, V cleared, keeps C, D, H.
// - compare subtracts only for flags; operands unchanged.
// - compare sets C on borrow, Z, S, V; keeps D and H.
// - compare opcodes A2 to A6 with their byte and cycle counts.
// - flags register lives at register address 0D5h.
package bbc_pkg;
  localparam logic [7:0] OP_BIT_OR    = 8'h07;
  localparam logic [7:0] OP_BIT_XOR   = 8'h27;
  localparam logic [7:0] OP_BIT_BR    = 8'h37;
  localparam logic [7:0] OP_BIT_BR_T  = 8'h37;
  localparam logic [7:0] OP_CALL      = 8'hF6;
  localparam logic [7:0] OP_CARRY_INV = 8'hEF;
  localparam logic [7:0] OP_ZERO_R    = 8'hB0;
  localparam logic [7:0] OP_ZERO_I    = 8'hB1;
  localparam logic [7:0] OP_INV_R     = 8'h60;
  localparam logic [7:0] OP_INV_I     = 8'h61;
  localparam logic [7:0] OP_RET       = 8'hAF;
  localparam logic [7:0] OP_CMP_RR    = 8'hA2;
  localparam logic [7:0] OP_CMP_RI    = 8'hA3;
  localparam logic [7:0] OP_CMP_GG    = 8'hA4;
  localparam logic [7:0] OP_CMP_GI    = 8'hA5;
  localparam logic [7:0] OP_CMP_IM    = 8'hA6;
  localparam logic [7:0] FLAGS_ADDR = 8'hD5;
  localparam logic [7:0] FLAGS_RST  = 8'h00;
  localparam logic [7:0] SP_RST     = 8'h00;
  localparam logic [15:0] PC_RST    = 16'h0000;
  localparam int FLAG_C = 7;
  localparam int FLAG_Z = 6;
  localparam int FLAG_S = 5;
  localparam int FLAG_V = 4;
  localparam int FLAG_D = 3;
  localparam int FLAG_H = 2;
  localparam logic [3:0] CYC_BTJ  = 4'hA;
  localparam logic [3:0] CYC_BIT  = 4'h6;
  localparam logic [3:0] CYC_CALL = 4'hE;
  localparam logic [3:0] CYC_2B   = 4'h4;
  localparam logic [3:0] CYC_3B   = 4'h6;
  localparam logic [3:0] CYC_RET  = 4'h8;
  localparam logic [15:0] LEN_2 = 16'h0002;
  localparam logic [15:0] LEN_3 = 16'h0003;
  localparam logic [15:0] LEN_1 = 16'h0001;

  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] byte2;
    logic [7:0] byte3;
  } bbc_instr_t;

  typedef struct packed {
    logic [3:0] reg_addr;
    logic [2:0] bit_idx;
    logic       sel;
  } bbc_bitfld_t;

  typedef enum logic [2:0] {
    BBC_IDLE,
    BBC_READ,
    BBC_EXEC,
    BBC_PUSH_HI,
    BBC_POP_LO,
    BBC_WAIT
  } bbc_state_t;
endpackage

// ---- bit_branch_call_compare_ops_tb.sv ----
`timescale 1ns/1ps
module bit_branch_call_compare_ops_tb;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic                clk_i;
  logic                arst_n_i;
  logic                start_i;
  bbc_pkg::bbc_instr_t instr_i;
  logic                true_sel_i;
  logic [7:0]          wr_addr_i;
  logic [7:0]          wr_data_i;
  logic                wr_en_i;
  logic [7:0]          rd_addr_i;
  logic                busy_o;
  logic                done_o;
  logic                illegal_o;
  logic [15:0]         pc_o;
  logic [7:0]          sp_o;
  logic [7:0]          flags_o;
  logic [7:0]          rd_data_o;
  int                  n_mismatch;
  int                  samples_checked;
  logic [15:0]         pc_m;

  bbc_core dut_u (
    .clk_i     (clk_i),
    .arst_n_i  (arst_n_i),
    .start_i   (start_i),
    .instr_i   (instr_i),
    .true_sel_i(true_sel_i),
    .wr_addr_i (wr_addr_i),
    .wr_data_i (wr_data_i),
    .wr_en_i   (wr_en_i),
    .rd_addr_i (rd_addr_i),
    .busy_o    (busy_o),
    .done_o    (done_o),
    .illegal_o (illegal_o),
    .pc_o      (pc_o),
    .sp_o      (sp_o),
    .flags_o   (flags_o),
    .rd_data_o (rd_data_o)
  );

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t ns: seen %0h expected %0h", $time,
               seen, exp);
    end
  endtask

  task automatic summarize();
    $display("mismatches %0d, comparisons %0d", n_mismatch,
             samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_en_i   <= 1'b1;
    wr_addr_i <= a;
    wr_data_i <= d;
    @(posedge clk_i);
    wr_en_i   <= 1'b0;
  endtask

  // read port is combinational; look once the address has landed
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    rd_addr_i <= a;
    #1;
    chk({8'h00, rd_data_o}, {8'h00, exp});
  endtask

  // issue one instruction, time its completion, then check the counter
  task automatic run(input logic [7:0] op, input logic [7:0] b2,
                     input logic [7:0] b3, input logic tsel,
                     input int ncyc, input logic [15:0] next_pc);
    int k;
    @(posedge clk_i);
    start_i    <= 1'b1;
    instr_i    <= '{op, b2, b3};
    true_sel_i <= tsel;
    @(posedge clk_i);
    start_i    <= 1'b0;
    for (k = 1; k <= 40; k++) begin
      @(posedge clk_i);
      #1;
      if (done_o === 1'b1) break;
    end
    if (k > 40) begin
      n_mismatch++;
      summarize();
    end
    chk(16'(k), 16'(ncyc - 2));
    chk(pc_o, next_pc);
    pc_m = next_pc;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_invert();
    wr(8'h20, 8'h07);
    wr(bbc_pkg::FLAGS_ADDR, 8'h8C);
    run(bbc_pkg::OP_INV_R, 8'h20, 8'h00, 1'b0, 4, pc_m + 16'h0002);
    rd_chk(8'h20, 8'hF8);
    chk({8'h00, flags_o}, 16'h00AC);
    wr(8'h20, 8'hFF);
    run(bbc_pkg::OP_INV_R, 8'h20, 8'h01, 1'b0, 4, pc_m + 16'h0002);
    rd_chk(8'h20, 8'h00);
    chk({8'h00, flags_o}, 16'h00CC);
    $display("test complement done");
  endtask

  task automatic t_carry();
    wr(bbc_pkg::FLAGS_ADDR, 8'h9C);
    run(bbc_pkg::OP_CARRY_INV, 8'h00, 8'h00, 1'b0, 4, pc_m + 16'h0001);
    chk({8'h00, flags_o}, 16'h001C);
    run(bbc_pkg::OP_CARRY_INV, 8'h00, 8'h01, 1'b0, 4, pc_m + 16'h0001);
    chk({8'h00, flags_o}, 16'h009C);
    $display("test carry invert done");
  endtask

  task automatic t_zero();
    wr(8'h30, 8'h4F);
    wr(8'h31, 8'h32);
    wr(8'h32, 8'h5E);
    run(bbc_pkg::OP_ZERO_R, 8'h30, 8'h00, 1'b0, 4, pc_m + 16'h0002);
    rd_chk(8'h30, 8'h00);
    run(bbc_pkg::OP_ZERO_I, 8'h31, 8'h00, 1'b0, 4, pc_m + 16'h0002);
    rd_chk(8'h32, 8'h00);
    rd_chk(8'h31, 8'h32);
    chk({8'h00, flags_o}, 16'h009C);
    $display("test clear done");
  endtask

  task automatic t_compare();
    logic [7:0] ops [5] = '{bbc_pkg::OP_CMP_RR, bbc_pkg::OP_CMP_RI,
                            bbc_pkg::OP_CMP_GG, bbc_pkg::OP_CMP_GI,
                            bbc_pkg::OP_CMP_IM};
    logic [7:0] b2s [5] = '{8'h12, 8'h13, 8'h51, 8'h53, 8'h52};
    logic [7:0] b3s [5] = '{8'h00, 8'h00, 8'h52, 8'h52, 8'h03};
    logic [15:0] lens [5] = '{16'h2, 16'h2, 16'h3, 16'h3, 16'h3};
    // every form compares 02h against 03h
    wr(8'hC1, 8'h02);
    wr(8'hC2, 8'h03);
    wr(8'hC3, 8'h50);
    wr(8'h50, 8'h03);
    wr(8'h51, 8'h03);
    wr(8'h52, 8'h02);
    wr(8'h53, 8'h51);
    for (int i = 0; i < 5; i++) begin
      wr(bbc_pkg::FLAGS_ADDR, 8'h0C);
      run(ops[i], b2s[i], b3s[i], 1'b0, (i == 0) ? 4 : 6, pc_m + lens[i]);
      chk({8'h00, flags_o}, 16'h00AC);
    end
    rd_chk(8'hC1, 8'h02);
    rd_chk(8'h52, 8'h02);
    run(bbc_pkg::OP_CMP_IM, 8'h52, 8'h02, 1'b0, 6, pc_m + 16'h0003);
    chk({8'h00, flags_o}, 16'h004C);
    wr(8'h52, 8'h80);
    run(bbc_pkg::OP_CMP_IM, 8'h52, 8'h01, 1'b0, 6, pc_m + 16'h0003);
    chk({8'h00, flags_o}, 16'h001C);
    $display("test compare done");
  endtask

  task automatic t_bits();
    wr(8'hC1, 8'h07);
    wr(8'h01, 8'h03);
    wr(bbc_pkg::FLAGS_ADDR, 8'hAC);
    run(bbc_pkg::OP_BIT_XOR, 8'h12, 8'h01, 1'b0, 6, pc_m + 16'h0003);
    rd_chk(8'hC1, 8'h06);
    rd_chk(8'h01, 8'h03);
    chk({8'h00, flags_o & 8'hAC}, 16'h008C);
    run(bbc_pkg::OP_BIT_OR, 8'h14, 8'h01, 1'b0, 6, pc_m + 16'h0003);
    rd_chk(8'hC1, 8'h06);
    run(bbc_pkg::OP_BIT_OR, 8'h12, 8'h01, 1'b0, 6, pc_m + 16'h0003);
    rd_chk(8'hC1, 8'h07);
    rd_chk(8'h01, 8'h03);
    // destination-bit form: bit 2 of 01h takes bit 0 of the working reg
    run(bbc_pkg::OP_BIT_OR, 8'h15, 8'h01, 1'b0, 6, pc_m + 16'h0003);
    rd_chk(8'h01, 8'h07);
    rd_chk(8'hC1, 8'h07);
    $display("test bit operations done");
  endtask

  task automatic t_branch();
    wr(8'hC1, 8'h07);
    wr(bbc_pkg::FLAGS_ADDR, 8'hFC);
    // bit 3 is clear: false form jumps forward
    // offsets stay inside the reachable span
    run(bbc_pkg::OP_BIT_BR, 8'h16, 8'h10, 1'b0, 10, pc_m + 16'h0013);
    run(bbc_pkg::OP_BIT_BR, 8'h12, 8'h10, 1'b0, 10, pc_m + 16'h0003);
    // bit 1 is set: true form jumps backward by 16
    run(bbc_pkg::OP_BIT_BR_T, 8'h12, 8'hF0, 1'b1, 10, pc_m - 16'h000D);
    run(bbc_pkg::OP_BIT_BR_T, 8'h16, 8'hF0, 1'b1, 10, pc_m + 16'h0003);
    chk({8'h00, flags_o}, 16'h00FC);
    $display("test bit branches done");
  endtask

  task automatic t_call();
    logic [15:0] ret_pc;
    ret_pc = pc_m + 16'h0003;
    run(bbc_pkg::OP_CALL, 8'h35, 8'h21, 1'b0, 14, 16'h3521);
    chk({8'h00, sp_o}, 16'h00FE);
    rd_chk(8'hFF, ret_pc[7:0]);
    rd_chk(8'hFE, ret_pc[15:8]);
    chk({8'h00, flags_o}, 16'h00FC);
    run(bbc_pkg::OP_RET, 8'h00, 8'h00, 1'b0, 8, ret_pc);
    chk({8'h00, sp_o}, 16'h0000);
    $display("test call and return done");
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    arst_n_i        = 1'b0;
    start_i         = 1'b0;
    instr_i         = '0;
    true_sel_i      = 1'b0;
    wr_en_i         = 1'b0;
    wr_addr_i       = 8'h00;
    wr_data_i       = 8'h00;
    rd_addr_i       = 8'h00;
    n_mismatch      = 0;
    samples_checked = 0;
    pc_m            = 16'h0000;
    repeat (12) @(posedge clk_i);
    arst_n_i <= 1'b1;
    #1;
    chk(pc_o, bbc_pkg::PC_RST);
    chk({8'h00, sp_o}, {8'h00, bbc_pkg::SP_RST});
    t_invert();
    t_carry();
    t_zero();
    t_compare();
    t_bits();
    t_branch();
    t_call();
    summarize();
  end
endmodule // bit_branch_call_compare_ops_tb
